// ---- logic/autoneg_np_pkg.sv ----
/*
  Package for the auto-negotiation next-page status register bank:
  register offsets, field positions, reset values, interrupt layout.
  Assumes a 32-bit AXI4-Lite master and one 100 MHz clock domain.
*/
// Functional notes
// R1 - Message flag set: code is message code
// R2 - Message flag clear: code passes unchanged
// R3 - Code field holds partner code, resets zero
// R4 - Comply-ack bit mirrors partner's ability, reset 0
// R5 - Toggle reads inverse of previous transmitted toggle
// R6 - Expansion bits 15:5 ignore writes, read zero
// R7 - Parallel detect fault bit reflects detector
// R8 - Partner next-page capable bit, reset 0
// R9 - Local next-page capable fixed at one
// R10 - Page received sets, clears on read
// R11 - Partner autoneg capable bit, reset 0
// R12 - Page bits loaded by negotiation, not software
// R13 - All next-page fields load together atomically
package autoneg_np_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_PARTNER_NP = 10'h005;
  localparam logic [9:0] IDX_EXPANSION = 10'h006;
  localparam logic [11:0] ADDR_PARTNER_NP = {IDX_PARTNER_NP, 2'h0};
  localparam logic [11:0] ADDR_EXPANSION = {IDX_EXPANSION, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h040;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h044;
  localparam logic [11:0] ADDR_PAGE_KIND = 12'h048;
  localparam int NP_MSG_BIT = 13;
  localparam int NP_PARTNER_COMPLY_ACK_BIT = 12;
  localparam int NP_TOGGLE_BIT = 11;
  localparam int NP_CODE_MSB = 10;
  localparam int EXP_PDF_BIT = 4;
  localparam int EXP_LP_NP_BIT = 3;
  localparam int EXP_NP_BIT = 2;
  localparam int EXP_PAGE_RX_BIT = 1;
  localparam int EXP_LP_AN_BIT = 0;
  localparam logic [10:0] CODE_RESET = 11'h000;
  localparam logic LOCAL_NP_VALUE = 1'b1;
  localparam int IRQ_PAGE_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- logic/autoneg_np_status.sv ----
/*
  Auto-negotiation next-page status registers behind an AXI4-Lite slave.
  Assumes the negotiation engine pulses page_accept for one aclk cycle
  with the whole received word stable, all inputs on aclk.
  One read and one write are in flight at most; a read is answered
  one cycle after its address is taken, a write after both halves.
*/
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module autoneg_np_status (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic page_accept, // Complete next page accepted
  input wire logic [15:0] rx_page_word, // Received link code word
  input wire logic prev_tx_toggle, // Toggle of previous sent word
  input wire logic parallel_detect_fault, // Parallel detection fault
  input wire logic partner_next_page_capable, // Partner supports next page
  input wire logic partner_autoneg_capable, // Partner supports autoneg
  output logic irq // Level interrupt
);
  import autoneg_np_pkg::*;

  logic message_page_flag_q;
  logic partner_comply_ack_q;
  logic toggle_q;
  logic [10:0] code_q;
  logic pdf_q;
  logic lp_np_q;
  logic lp_an_q;
  logic page_rx_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  logic fault_prev_q;
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  typedef enum {
    SEL_PARTNER_NP,
    SEL_EXPANSION,
    SEL_IRQ_STATUS,
    SEL_IRQ_MASK,
    SEL_PAGE_KIND,
    SEL_NONE
  } reg_sel_t;

  logic do_write;
  logic do_read;
  logic aw_take;
  logic w_take;
  logic b_take;
  logic r_take;
  logic read_busy_next;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic page_read;
  logic status_write;
  logic mask_write;
  logic fault_rise;
  logic [1:0] irq_event;

  // Address to register select, shared by both channels
  function automatic reg_sel_t decode_addr(input logic [11:0] a);
    if (a == ADDR_PARTNER_NP) begin
      decode_addr = SEL_PARTNER_NP;
    end else if (a == ADDR_EXPANSION) begin
      decode_addr = SEL_EXPANSION;
    end else if (a == ADDR_IRQ_STATUS) begin
      decode_addr = SEL_IRQ_STATUS;
    end else if (a == ADDR_IRQ_MASK) begin
      decode_addr = SEL_IRQ_MASK;
    end else if (a == ADDR_PAGE_KIND) begin
      decode_addr = SEL_PAGE_KIND;
    end else begin
      decode_addr = SEL_NONE;
    end
  endfunction

  function automatic logic is_mapped(input reg_sel_t sel);
    is_mapped = (sel != SEL_NONE);
  endfunction

  // Handshakes and decoded strobes
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign b_take = s_axi_bvalid && s_axi_bready;
  assign r_take = s_axi_rvalid && s_axi_rready;
  assign wr_sel = decode_addr(awaddr_q);
  assign rd_sel = decode_addr(s_axi_araddr);
  assign page_read = do_read && (rd_sel == SEL_EXPANSION);
  assign status_write = do_write && (wr_sel == SEL_IRQ_STATUS) && wstrb_q[0];
  assign mask_write = do_write && (wr_sel == SEL_IRQ_MASK) && wstrb_q[0];
  assign fault_rise = parallel_detect_fault && !fault_prev_q;
  assign irq_event[IRQ_PAGE_BIT] = page_accept;
  assign irq_event[IRQ_FAULT_BIT] = fault_rise;

  // Write channel: accept address and data in either order
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      s_axi_awready <= 1'b0;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held_q <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(wr_sel) ? RESP_OKAY : RESP_SLVERR;
    end else if (b_take) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  assign do_read = s_axi_arvalid && s_axi_arready;
  // Ready never waits on valid, so a master holding arvalid cannot stall
  assign read_busy_next = do_read || (s_axi_rvalid && !s_axi_rready);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !read_busy_next;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    if (rd_sel == SEL_PARTNER_NP) begin
      rd_word[NP_MSG_BIT] = message_page_flag_q;
      rd_word[NP_PARTNER_COMPLY_ACK_BIT] = partner_comply_ack_q; // [R4]
      rd_word[NP_TOGGLE_BIT] = toggle_q;
      rd_word[NP_CODE_MSB:0] = code_q; // [R1] [R2] [R3]
    end else if (rd_sel == SEL_EXPANSION) begin
      // Bits 15:5 stay zero [R6]
      rd_word[EXP_PDF_BIT] = pdf_q; // [R7]
      rd_word[EXP_LP_NP_BIT] = lp_np_q; // [R8]
      rd_word[EXP_NP_BIT] = LOCAL_NP_VALUE; // [R9]
      rd_word[EXP_PAGE_RX_BIT] = page_rx_q; // [R10]
      rd_word[EXP_LP_AN_BIT] = lp_an_q; // [R11]
    end else if (rd_sel == SEL_IRQ_STATUS) begin
      rd_word[1:0] = irq_status_q;
    end else if (rd_sel == SEL_IRQ_MASK) begin
      rd_word[1:0] = irq_mask_q;
    end else if (rd_sel == SEL_PAGE_KIND) begin
      rd_word[0] = message_page_flag_q; // [R1]
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_resp;
    end else if (r_take) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Next-page fields: loaded only by the engine, all at once [R12] [R13]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      message_page_flag_q <= 1'b0;
      partner_comply_ack_q <= 1'b0;
      toggle_q <= 1'b0;
      code_q <= CODE_RESET; // [R3]
    end else if (page_accept) begin
      message_page_flag_q <= rx_page_word[NP_MSG_BIT];
      partner_comply_ack_q <= rx_page_word[NP_PARTNER_COMPLY_ACK_BIT]; // [R4]
      toggle_q <= !prev_tx_toggle; // [R5]
      code_q <= rx_page_word[NP_CODE_MSB:0]; // [R1] [R2]
    end
  end

  // Expansion status levels, one cycle behind the engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pdf_q <= 1'b0;
    end else begin
      pdf_q <= parallel_detect_fault; // [R7]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_np_q <= 1'b0;
    end else begin
      lp_np_q <= partner_next_page_capable; // [R8]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_an_q <= 1'b0;
    end else begin
      lp_an_q <= partner_autoneg_capable; // [R11]
    end
  end

  // Page received: set wins over clear-on-read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_rx_q <= 1'b0;
    end else if (page_accept) begin
      page_rx_q <= 1'b1; // [R10]
    end else if (page_read) begin
      page_rx_q <= 1'b0; // [R10]
    end
  end

  // Fault edge detector; reset matches the idle low level of the input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_prev_q <= 1'b0;
    end else begin
      fault_prev_q <= parallel_detect_fault;
    end
  end

  // Sticky status bit per event, write one to clear, set wins
  for (genvar i = 0; i < 2; i++) begin : g_irq_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        irq_status_q[i] <= 1'b0;
      end else if (irq_event[i]) begin
        irq_status_q[i] <= 1'b1;
      end else if (status_write && wdata_q[i]) begin
        irq_status_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (mask_write) begin
      irq_mask_q <= wdata_q[1:0];
    end
  end

  // Level interrupt, registered so the pin comes from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_mask_q);
    end
  end
endmodule
`default_nettype wire

// ---- verif/autoneg_np_status_chk.sv ----
/* Checker for the next-page status bank.
   Sees only the top ports; bound to the top below. */
`timescale 1ns/100ps
`default_nettype none
module autoneg_np_status_chk
  import autoneg_np_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic [11:0] s_axi_araddr, // Rd addr
  input wire logic s_axi_arvalid, // Rd valid
  input wire logic s_axi_arready, // Rd ready
  input wire logic [31:0] s_axi_rdata, // Rd data
  input wire logic s_axi_rvalid, // Rd data valid
  input wire logic s_axi_rready, // Rd data ready
  input wire logic [1:0] s_axi_bresp, // Wr resp
  input wire logic s_axi_bvalid, // Wr resp valid
  input wire logic s_axi_bready, // Wr resp ready
  input wire logic page_accept // Page load
);
  logic exp_q, clr_q, pend_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Which register the pending read targets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exp_q <= 1'b0;
      clr_q <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      exp_q <= s_axi_araddr == ADDR_EXPANSION;
      clr_q <= s_axi_araddr == ADDR_EXPANSION && !pend_q;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) pend_q <= 1'b0;
    else if (page_accept) pend_q <= 1'b1;
    else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_EXPANSION) pend_q <= 1'b0;
  end
  AST_RSVD: assert property (s_axi_rvalid && exp_q |-> s_axi_rdata[15:5] == 11'h000)
    else $error("expansion reserved bits set");
  AST_NP_ONE: assert property (s_axi_rvalid && exp_q |-> s_axi_rdata[2])
    else $error("local next page bit low");
  AST_PRX_CLR: assert property (s_axi_rvalid && clr_q |-> !s_axi_rdata[1])
    else $error("page received not cleared");
  AST_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_AR_QUIET: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  cover property (s_axi_rvalid && exp_q && s_axi_rdata[1]);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
endmodule
bind autoneg_np_status autoneg_np_status_chk u_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .page_accept);
`default_nettype wire

// ---- verif/autoneg_np_status_tb.sv ----
/* Bench for the next-page status bank: bus access, page loads, interrupt.
   Assumes the package and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module autoneg_np_status_tb;
  import autoneg_np_pkg::*;
  logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, page_accept = '0, prev_tx_toggle = '0;
  logic parallel_detect_fault = '0, partner_next_page_capable = '0, partner_autoneg_capable = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, w;
  logic [3:0] s_axi_wstrb = '0;
  logic [15:0] rx_page_word = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, bq[$];
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, t, f, np, an;
  logic [33:0] rq[$];
  int err_total = 0, check_count = 0;
  autoneg_np_status u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .page_accept,
    .rx_page_word, .prev_tx_toggle, .parallel_detect_fault, .partner_next_page_capable,
    .partner_autoneg_capable, .irq);
  always #5 aclk = ~aclk;
  task summarize;
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [33:0] s, e, input string nm);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task step(inout int n);
    @(posedge aclk);
    n++;
  endtask
  task lim(input int n);
    if (n >= 50) begin
      err_total++;
      summarize();
    end
  endtask
  // Results checked oldest first as they appear
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front(), "rdata");
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) chk(s_axi_bresp, bq.pop_front(), "bresp");
  end
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic pa, pw;
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {pa, pw} = 2'h3;
    n = 0;
    while ((pa || pw) && n < 50) begin
      step(n);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    while (!s_axi_bvalid && n < 50) step(n);
    s_axi_bready <= 1'b0;
    lim(n);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    int n;
    rq.push_back({RESP_OKAY, e});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do step(n); while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do step(n); while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    lim(n);
  endtask
  initial begin
    void'($urandom(34795));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_PARTNER_NP, '0);
    rd(ADDR_EXPANSION, 32'h4);
    wr(ADDR_EXPANSION, 32'hFFFF, RESP_OKAY);
    wr(ADDR_PARTNER_NP, 32'hFFFF, RESP_OKAY);
    wr(12'h0FC, '1, RESP_SLVERR);
    rd(ADDR_EXPANSION, 32'h4);
    rd(ADDR_PARTNER_NP, '0);
    for (int i = 0; i < 6; i++) begin
      w = $urandom;
      w[13] = i[0];
      {t, f, np, an} = 4'($urandom);
      @(posedge aclk);
      rx_page_word <= w[15:0];
      prev_tx_toggle <= t;
      {parallel_detect_fault, partner_next_page_capable, partner_autoneg_capable} <= {f, np, an};
      page_accept <= 1'b1;
      @(posedge aclk);
      page_accept <= 1'b0;
      rx_page_word <= ~w[15:0];
      repeat (3) @(posedge aclk);
      rd(ADDR_PARTNER_NP, {18'h0, w[13:12], ~t, w[10:0]});
      rd(ADDR_PAGE_KIND, 32'(w[13]));
      rd(ADDR_EXPANSION, {27'h0, f, np, 2'h3, an});
      rd(ADDR_EXPANSION, {27'h0, f, np, 2'h2, an});
    end
    chk(irq, '0, "irq");
    wr(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
    rd(ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk(irq, 34'h1, "irq");
    wr(ADDR_IRQ_STATUS, 32'h3, RESP_OKAY);
    rd(ADDR_IRQ_STATUS, '0);
    chk(irq, '0, "irq");
    wr(ADDR_IRQ_MASK, 32'h2, RESP_OKAY);
    parallel_detect_fault <= 1'b0;
    repeat (2) @(posedge aclk);
    parallel_detect_fault <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(ADDR_IRQ_STATUS, 32'h2);
    chk(irq, 34'h1, "irq");
    wr(ADDR_IRQ_STATUS, 32'h2, RESP_OKAY);
    rd(ADDR_IRQ_STATUS, '0);
    chk(irq, '0, "irq");
    summarize();
  end
endmodule
`default_nettype wire
